// >>> src/emc_ctrl.sv
// Purpose: control, status and mac configuration of the ethernet module
// Assumes: mac core, dma and buffer arbiter run on ref_clk
// Notes: a 16-word fifo decouples received bytes from the buffer writer
`include "emc_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module emc_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16,
   parameter int LW = $clog2(DEPTH + 1)
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic flush,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [LW-1:0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [LW-1:0] cnt_r;
   logic push;
   logic pop;

   assign in_ready = (cnt_r != LW'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rp_r];
   assign level = cnt_r;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clk)
   begin
      if (push)
         mem_r[wp_r] <= in_data;
   end

   always_ff @(posedge clk)
   begin
      if (reset | flush)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
            wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
         if (pop)
            rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
         if (push & !pop)
            cnt_r <= cnt_r + 1'b1;
         else if (pop & !push)
            cnt_r <= cnt_r - 1'b1;
      end
   end
endmodule

module emc_ctrl #(
   parameter int PTR_W = 13,
   parameter int FIFO_DEPTH = 16,
   parameter int PHY_START_CYCLES = 1000
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // register port
   input wire logic [3:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // buffer data port
   input wire logic [7:0] buf_rd_data,
   output logic [PTR_W-1:0] buffer_read_pointer,
   output logic buf_wr_req,
   output logic [PTR_W-1:0] buf_wr_addr,
   output logic [7:0] buf_wdata,
   // engines
   output logic tx_start,
   input wire logic tx_done,
   input wire logic tx_aborted,
   output logic dma_start,
   output logic dma_checksum_select,
   input wire logic dma_done,
   input wire logic buf_error,
   input wire logic buf_error_tx,
   output logic transmit_logic_reset,
   output logic receive_logic_reset,
   output logic transmit_error_irq_flag,
   output logic receive_error_irq_flag,
   output logic phy_ready_flag,
   // mac configuration
   output logic pause_transmit_enable,
   output logic pause_receive_enable,
   output logic pad_enable,
   output logic pad_to_64,
   output logic pad_vlan_auto,
   output logic transmit_crc_enable,
   output logic [2:0] crc_skip_bytes,
   output logic huge_frame_enable,
   output logic length_check_enable,
   output logic full_duplex_enable,
   input wire logic [15:0] max_frame_length,
   // received stream from the mac
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [7:0] rx_data,
   input wire logic rx_sof,
   input wire logic rx_eof,
   input wire logic rx_is_ctrl,
   input wire logic rx_filter_pass,
   // stream toward the buffer writer
   output logic rxb_valid,
   input wire logic rxb_ready,
   output logic [7:0] rxb_data,
   output logic rxb_last
);
   localparam int LW = $clog2(FIFO_DEPTH + 1);
   localparam int PW = $clog2(PHY_START_CYCLES + 1);

   function automatic logic hit(input logic [3:0] a, input logic [3:0] want);
      hit = (a == want);
   endfunction

   // even codes never pad; the vlan code leaves type detection to the mac
   function automatic logic [2:0] pad_decode(input logic [2:0] code);
      pad_decode = {code[0], code[0] & code[1], code[0] & code[2] & !code[1]};
   endfunction

   logic [7:0] main_r;
   logic [7:0] main_nxt;
   logic [7:0] aux_r;
   logic [7:0] mac1_r;
   logic [7:0] mac3_r;
   logic buf_err_r;
   logic tx_abort_r;
   logic [7:0] pkt_cnt_r;
   logic [PTR_W-1:0] wr_ptr_r;
   logic [PW-1:0] phy_cnt_r;
   logic tx_start_r;
   logic dma_start_r;
   emc_pkg::emc_rx_state_t rx_st_r;
   logic [15:0] frm_cnt_r;
   logic rx_ready_r;
   logic rxb_valid_r;
   logic [8:0] rxb_word_r;
   logic [7:0] rd_mux;
   logic wr_main;
   logic wr_stat;
   logic data_rd;
   logic data_wr;
   logic pkt_dec;
   logic module_enable;
   logic rx_on;
   logic start_ok;
   logic rx_take;
   logic in_frame;
   logic keep_byte;
   logic push;
   logic pkt_inc;
   logic rx_err;
   logic rx_busy;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [8:0] fifo_out_data;
   logic [LW-1:0] fifo_level;
   logic [15:0] cur_idx;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   assign wr_main = sfr_wr & hit(sfr_addr, `EMC_A_MAIN);
   assign wr_stat = sfr_wr & hit(sfr_addr, `EMC_A_STAT);
   assign data_rd = sfr_rd & hit(sfr_addr, `EMC_A_DATA);
   assign data_wr = sfr_wr & hit(sfr_addr, `EMC_A_DATA);
   assign pkt_dec = sfr_wr & hit(sfr_addr, `EMC_A_AUX) & sfr_wdata[`EMC_B_PKT_DEC];
   assign module_enable = aux_r[`EMC_B_MOD_EN];
   assign rx_err = buf_error & !buf_error_tx;

   // software write wins over a hardware clear landing in the same cycle
   always_comb
   begin
      main_nxt = main_r;
      if (dma_done)
         main_nxt[`EMC_B_DMA_GO] = 1'b0;
      if (tx_done | tx_aborted)
         main_nxt[`EMC_B_TX_REQ] = 1'b0;
      if (wr_main)
         main_nxt = sfr_wdata & `EMC_MASK_MAIN;
      if (main_nxt[`EMC_B_TX_RST] | !module_enable)
         main_nxt[`EMC_B_TX_REQ] = 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         main_r <= `EMC_RST_MAIN;
      else
         main_r <= main_nxt;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         tx_start_r <= 1'b0;
         dma_start_r <= 1'b0;
         transmit_logic_reset <= 1'b1;
         receive_logic_reset <= 1'b1;
      end
      else
      begin
         tx_start_r <= main_nxt[`EMC_B_TX_REQ] & !main_r[`EMC_B_TX_REQ];
         dma_start_r <= main_nxt[`EMC_B_DMA_GO] & !main_r[`EMC_B_DMA_GO];
         transmit_logic_reset <= main_nxt[`EMC_B_TX_RST] | !module_enable;
         receive_logic_reset <= main_nxt[`EMC_B_RX_RST] | !module_enable;
      end
   end

   assign tx_start = tx_start_r;
   assign dma_start = dma_start_r;
   assign dma_checksum_select = main_r[`EMC_B_CSUM];

   // the decrement bit is never stored, so it always reads back zero
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         aux_r <= `EMC_RST_AUX;
      else if (sfr_wr & hit(sfr_addr, `EMC_A_AUX))
         aux_r <= sfr_wdata & `EMC_MASK_AUX;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         mac1_r <= `EMC_RST_MAC1;
         mac3_r <= `EMC_RST_MAC3;
      end
      else
      begin
         if (sfr_wr & hit(sfr_addr, `EMC_A_MAC1))
            mac1_r <= sfr_wdata & `EMC_MASK_MAC1;
         if (sfr_wr & hit(sfr_addr, `EMC_A_MAC3))
            mac3_r <= sfr_wdata;
      end
   end

   assign pause_transmit_enable = mac1_r[`EMC_B_PAUSE_TX];
   assign pause_receive_enable = mac1_r[`EMC_B_PAUSE_RX];
   assign transmit_crc_enable = mac3_r[`EMC_B_CRC_EN];
   assign huge_frame_enable = mac3_r[`EMC_B_HUGE];
   assign length_check_enable = mac3_r[`EMC_B_LEN_CHK];
   assign full_duplex_enable = mac3_r[`EMC_B_FDX];

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         {pad_enable, pad_to_64, pad_vlan_auto} <= 3'h0;
         crc_skip_bytes <= 3'h0;
      end
      else
      begin
         {pad_enable, pad_to_64, pad_vlan_auto} <=
            pad_decode(mac3_r[`EMC_B_PAD_HI:`EMC_B_PAD_LO]);
         crc_skip_bytes <= mac3_r[`EMC_B_HDR_EN] ? `EMC_HDR_BYTES : 3'h0;
      end
   end

   // sticky flags: software writes zero to clear, a new event wins
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         buf_err_r <= 1'b0;
         tx_abort_r <= 1'b0;
         transmit_error_irq_flag <= 1'b0;
         receive_error_irq_flag <= 1'b0;
      end
      else
      begin
         buf_err_r <= buf_error |
            (buf_err_r & !(wr_stat & !sfr_wdata[`EMC_B_BUF_ERR]));
         tx_abort_r <= tx_aborted |
            (tx_abort_r & !(wr_stat & !sfr_wdata[`EMC_B_TX_ABORT]));
         transmit_error_irq_flag <= (buf_error & buf_error_tx) | (transmit_error_irq_flag &
            !(sfr_wr & hit(sfr_addr, `EMC_A_ERRF) & !sfr_wdata[`EMC_B_TX_ERR]));
         receive_error_irq_flag <= rx_err | (receive_error_irq_flag &
            !(sfr_wr & hit(sfr_addr, `EMC_A_ERRF) & !sfr_wdata[`EMC_B_RX_ERR]));
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset | !module_enable)
      begin
         phy_cnt_r <= '0;
         phy_ready_flag <= 1'b0;
      end
      else if (phy_cnt_r != PW'(PHY_START_CYCLES))
         phy_cnt_r <= phy_cnt_r + 1'b1;
      else
         phy_ready_flag <= 1'b1;
   end

   // pointers wrap at the buffer size
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         buffer_read_pointer <= '0;
         wr_ptr_r <= '0;
      end
      else
      begin
         if (sfr_wr & hit(sfr_addr, `EMC_A_RDL))
            buffer_read_pointer[7:0] <= sfr_wdata;
         else if (sfr_wr & hit(sfr_addr, `EMC_A_RDH))
            buffer_read_pointer[PTR_W-1:8] <= sfr_wdata[PTR_W-9:0];
         else if (data_rd & aux_r[`EMC_B_AUTO_INC])
            buffer_read_pointer <= buffer_read_pointer + 1'b1;
         if (sfr_wr & hit(sfr_addr, `EMC_A_WRL))
            wr_ptr_r[7:0] <= sfr_wdata;
         else if (sfr_wr & hit(sfr_addr, `EMC_A_WRH))
            wr_ptr_r[PTR_W-1:8] <= sfr_wdata[PTR_W-9:0];
         else if (data_wr & aux_r[`EMC_B_AUTO_INC])
            wr_ptr_r <= wr_ptr_r + 1'b1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         buf_wr_req <= 1'b0;
         buf_wr_addr <= '0;
         buf_wdata <= 8'h00;
      end
      else
      begin
         buf_wr_req <= data_wr;
         if (data_wr)
         begin
            buf_wr_addr <= wr_ptr_r;
            buf_wdata <= sfr_wdata;
         end
      end
   end

   assign rx_busy = (rx_st_r != emc_pkg::EMC_RX_IDLE);

   always_comb
   begin
      rd_mux = 8'h00;
      unique case (sfr_addr)
         `EMC_A_MAIN: rd_mux = main_r;
         `EMC_A_AUX: rd_mux = aux_r;
         `EMC_A_STAT: rd_mux = {1'b0, buf_err_r, 3'h0, rx_busy, tx_abort_r, phy_ready_flag};
         `EMC_A_MAC1: rd_mux = mac1_r;
         `EMC_A_MAC3: rd_mux = mac3_r;
         `EMC_A_DATA: rd_mux = buf_rd_data;
         `EMC_A_RDL: rd_mux = buffer_read_pointer[7:0];
         `EMC_A_RDH: rd_mux = 8'(buffer_read_pointer[PTR_W-1:8]);
         `EMC_A_WRL: rd_mux = wr_ptr_r[7:0];
         `EMC_A_WRH: rd_mux = 8'(wr_ptr_r[PTR_W-1:8]);
         `EMC_A_PKTCNT: rd_mux = pkt_cnt_r;
         `EMC_A_ERRF: rd_mux = {6'h00, transmit_error_irq_flag, receive_error_irq_flag};
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         sfr_rdata <= 8'h00;
      else if (sfr_rd)
         sfr_rdata <= rd_mux;
   end

   // receive path: frame kept or dropped on its first byte; a later error or disable drops the rest
   assign rx_on = module_enable & !main_r[`EMC_B_RX_RST] & main_r[`EMC_B_RX_EN] &
      mac1_r[`EMC_B_MAC_RX_EN];
   assign start_ok = rx_on & rx_filter_pass &
      (!rx_is_ctrl | mac1_r[`EMC_B_PASS_CTRL]);
   assign rx_take = rx_valid & rx_ready_r;
   assign in_frame = rx_sof ? start_ok : (rx_st_r == emc_pkg::EMC_RX_KEEP) & rx_on;
   assign cur_idx = rx_sof ? 16'h0000 : frm_cnt_r;
   // the closing byte of a kept frame skips the length limit so a truncated frame still ends
   assign keep_byte = rx_take & in_frame & !rx_err & (mac3_r[`EMC_B_HUGE] |
      (cur_idx < max_frame_length) | rx_eof);
   assign push = keep_byte & fifo_in_ready;
   assign pkt_inc = push & rx_eof;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         rx_st_r <= emc_pkg::EMC_RX_IDLE;
         frm_cnt_r <= 16'h0000;
      end
      else if (main_r[`EMC_B_RX_RST] | !module_enable)
         rx_st_r <= emc_pkg::EMC_RX_IDLE;
      else
      begin
         if (rx_take)
         begin
            if (rx_eof)
               rx_st_r <= emc_pkg::EMC_RX_IDLE;
            else if (rx_sof)
               rx_st_r <= start_ok & !rx_err ? emc_pkg::EMC_RX_KEEP : emc_pkg::EMC_RX_DROP;
            else if (!in_frame | rx_err)
               rx_st_r <= emc_pkg::EMC_RX_DROP;
            if (cur_idx != 16'hffff)
               frm_cnt_r <= cur_idx + 16'h0001;
         end
         else if (rx_err & (rx_st_r == emc_pkg::EMC_RX_KEEP))
            rx_st_r <= emc_pkg::EMC_RX_DROP;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         pkt_cnt_r <= 8'h00;
      else if (pkt_inc & !pkt_dec & (pkt_cnt_r != 8'hff))
         pkt_cnt_r <= pkt_cnt_r + 8'h01;
      else if (pkt_dec & !pkt_inc & (pkt_cnt_r != 8'h00))
         pkt_cnt_r <= pkt_cnt_r - 8'h01;
   end

   // ready looks one write ahead because it is registered
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         rx_ready_r <= 1'b0;
      else
         rx_ready_r <= (int'(fifo_level) + int'(push)) < (FIFO_DEPTH - 1);
   end

   assign rx_ready = rx_ready_r;

   emc_fifo #(
      .WIDTH(9),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(ref_clk),
      .reset(reset),
      .flush(receive_logic_reset),
      .in_valid(keep_byte),
      .in_ready(fifo_in_ready),
      .in_data({rx_eof, rx_data}),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data),
      .level(fifo_level)
   );

   assign fifo_out_ready = !rxb_valid_r | rxb_ready;

   always_ff @(posedge ref_clk)
   begin
      if (reset | receive_logic_reset)
      begin
         rxb_valid_r <= 1'b0;
         rxb_word_r <= 9'h000;
      end
      else if (fifo_out_ready)
      begin
         rxb_valid_r <= fifo_out_valid;
         if (fifo_out_valid)
            rxb_word_r <= fifo_out_data;
      end
   end

   assign rxb_valid = rxb_valid_r;
   assign rxb_data = rxb_word_r[7:0];
   assign rxb_last = rxb_word_r[8];

   a_transmit_logic_reset_holds: assert property (main_r[`EMC_B_TX_RST] |-> transmit_logic_reset)
      else $error("transmit logic not held in reset");
   a_dma_start_once: assert property ($rose(main_r[`EMC_B_DMA_GO]) |-> dma_start_r)
      else $error("dma start pulse missing");
   a_txreq_clears: assert property (((tx_done | tx_aborted) & !wr_main) |=>
      !main_r[`EMC_B_TX_REQ])
      else $error("transmit request not cleared");
   a_rx_discard: assert property (push |-> (rx_on & (rx_sof | rx_st_r == emc_pkg::EMC_RX_KEEP)))
      else $error("byte kept while receive disabled");
   a_rdptr_pointer_auto_increment: assert property ((data_rd & aux_r[`EMC_B_AUTO_INC] & !sfr_wr) |=>
      buffer_read_pointer == $past(buffer_read_pointer) + 1'b1)
      else $error("read pointer did not advance");
   a_packet_count_decrement_count: assert property ((pkt_dec & !pkt_inc & pkt_cnt_r != 8'h00) |=>
      (pkt_cnt_r == $past(pkt_cnt_r) - 8'h01) && !aux_r[`EMC_B_PKT_DEC])
      else $error("packet counter not decremented");
   a_buferr_sticky: assert property ((buf_error ##1 !wr_stat) |-> buf_err_r [*2])
      else $error("buffer error flag not sticky");
   a_err_side: assert property ((buf_error & buf_error_tx) |=> transmit_error_irq_flag)
      else $error("transmit error flag not set");
   a_abort_flag: assert property ((tx_aborted & !wr_main) |=>
      tx_abort_r && !main_r[`EMC_B_TX_REQ])
      else $error("abort flag or request wrong");
   a_phy_wait: assert property ($rose(module_enable) |=> !phy_ready_flag [*8])
      else $error("phy ready before timer expired");
   a_busy_frame: assert property ((rx_take & rx_sof & !rx_eof & rx_on &
      !main_r[`EMC_B_RX_RST]) |=> rx_busy)
      else $error("receive busy not raised");

   c_frame_kept: cover property (pkt_inc);
   c_fifo_full: cover property (!fifo_in_ready);
   c_tx_abort: cover property (main_r[`EMC_B_TX_REQ] ##1 tx_aborted);
   c_truncate: cover property (rx_take & in_frame & !keep_byte);
endmodule

`default_nettype wire

// >>> src/emc_consts.svh
// Purpose: constants for the ethernet module control and mac configuration block
// Assumes: 8-bit register port, one register per index
// Notes: all offsets and field positions live here, with the reset values of main, aux, mac1 and mac3
`ifndef EMC_CONSTS_SVH
`define EMC_CONSTS_SVH
`define EMC_A_MAIN 4'h0
`define EMC_A_AUX 4'h1
`define EMC_A_STAT 4'h2
`define EMC_A_MAC1 4'h3
`define EMC_A_MAC3 4'h4
`define EMC_A_DATA 4'h5
`define EMC_A_RDL 4'h6
`define EMC_A_RDH 4'h7
`define EMC_A_WRL 4'h8
`define EMC_A_WRH 4'h9
`define EMC_A_PKTCNT 4'ha
`define EMC_A_ERRF 4'hb
`define EMC_B_TX_RST 7
`define EMC_B_RX_RST 6
`define EMC_B_DMA_GO 5
`define EMC_B_CSUM 4
`define EMC_B_TX_REQ 3
`define EMC_B_RX_EN 2
`define EMC_B_AUTO_INC 7
`define EMC_B_PKT_DEC 6
`define EMC_B_MOD_EN 5
`define EMC_B_BUF_ERR 6
`define EMC_B_RX_BUSY 2
`define EMC_B_TX_ABORT 1
`define EMC_B_PHY_RDY 0
`define EMC_B_PAUSE_TX 3
`define EMC_B_PAUSE_RX 2
`define EMC_B_PASS_CTRL 1
`define EMC_B_MAC_RX_EN 0
`define EMC_B_PAD_HI 7
`define EMC_B_PAD_LO 5
`define EMC_B_CRC_EN 4
`define EMC_B_HDR_EN 3
`define EMC_B_HUGE 2
`define EMC_B_LEN_CHK 1
`define EMC_B_FDX 0
`define EMC_B_TX_ERR 1
`define EMC_B_RX_ERR 0
`define EMC_RST_MAIN 8'h00
`define EMC_RST_AUX 8'h80
`define EMC_RST_MAC1 8'h00
`define EMC_RST_MAC3 8'h00
`define EMC_MASK_MAIN 8'hfc
`define EMC_MASK_AUX 8'ha0
`define EMC_MASK_MAC1 8'h0f
`define EMC_HDR_BYTES 3'h4
`endif

// >>> src/emc_pkg.sv
// Purpose: shared types of the ethernet module control block
// Assumes: nothing beyond the constants header
// Notes: receive path frame state
package emc_pkg;
   typedef enum logic [1:0] {EMC_RX_IDLE, EMC_RX_KEEP, EMC_RX_DROP} emc_rx_state_t;
endpackage

// >>> verif/emc_far_model.sv
// Purpose: far side model, mac receive stream and tx/dma engines
// Assumes: four-byte frame per send pulse, engines answer 9 cycles late
// Notes: idle data line toggles so a stale byte never looks valid
`timescale 1ns/1ns
`default_nettype none
module emc_far_model (
   // clock and bench control
   input wire logic ref_clk,
   input wire logic send,
   input wire logic [7:0] seed,
   // engines
   input wire logic tx_start,
   input wire logic dma_start,
   output logic tx_aborted,
   output logic dma_done,
   // receive stream
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [7:0] rx_data,
   output logic rx_sof,
   output logic rx_eof
);
   logic [7:0] tx_d_r, dma_d_r;
   logic [2:0] cnt_r;
   initial {rx_valid, rx_sof, rx_eof, tx_aborted, dma_done, tx_d_r, dma_d_r, cnt_r, rx_data} = '0;
   // slow answers keep the request bits visible long enough to read
   always @(posedge ref_clk)
   begin
      tx_d_r <= {tx_d_r[6:0], tx_start};
      dma_d_r <= {dma_d_r[6:0], dma_start};
      tx_aborted <= tx_d_r[7];
      dma_done <= dma_d_r[7];
      if (send && !rx_valid)
      begin
         {rx_valid, rx_sof, rx_eof, cnt_r} <= 6'b110000;
         rx_data <= seed;
      end
      else if (rx_valid && rx_ready)
      begin
         rx_valid <= cnt_r != 3'h3;
         rx_sof <= 1'b0;
         rx_eof <= cnt_r == 3'h2;
         cnt_r <= cnt_r + 3'h1;
         rx_data <= cnt_r == 3'h3 ? ~rx_data : rx_data + 8'h01;
      end
      else if (!rx_valid)
         rx_data <= ~rx_data;
   end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Purpose: self-checking bench of emc_ctrl
// Assumes: phy start-up shortened to 10 cycles
// Notes: xorshift values, fixed seed; mac registers always spaced by a cycle
`include "emc_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic ref_clk, reset, sfr_wr, sfr_rd, send, rxb_ready, buf_error, buf_error_tx;
   logic tx_start, tx_aborted, dma_start, dma_done, dma_checksum_select, tlr, rlr;
   logic pte, pre, pad_enable, pad_to_64, pad_vlan_auto, tce, hfe, lce, fde;
   logic rx_valid, rx_ready, rx_sof, rx_eof, rxb_valid, rxb_last, bwr, ctl;
   logic [3:0] sfr_addr;
   logic [7:0] sfr_wdata, sfr_rdata, buf_rd_data, buf_wdata, rx_data, rxb_data, seed, v;
   logic [12:0] rdp, buf_wr_addr;
   logic [2:0] crc_skip_bytes;
   logic [31:0] rnd;
   int mismatches, n_tests, cyc, n;
   emc_ctrl #(.PHY_START_CYCLES(10)) u_emc_ctrl (.ref_clk, .reset, .sfr_addr, .sfr_wr, .sfr_rd,
      .sfr_wdata, .sfr_rdata, .buf_rd_data, .buffer_read_pointer(rdp), .buf_wr_req(bwr),
      .buf_wr_addr, .buf_wdata, .tx_start, .tx_done(1'b0), .tx_aborted, .dma_start,
      .dma_checksum_select, .dma_done, .buf_error, .buf_error_tx, .transmit_logic_reset(tlr),
      .receive_logic_reset(rlr), .transmit_error_irq_flag(), .receive_error_irq_flag(),
      .phy_ready_flag(), .pause_transmit_enable(pte), .pause_receive_enable(pre), .pad_enable,
      .pad_to_64, .pad_vlan_auto, .transmit_crc_enable(tce), .crc_skip_bytes,
      .huge_frame_enable(hfe), .length_check_enable(lce), .full_duplex_enable(fde),
      .max_frame_length(16'h05ee), .rx_valid, .rx_ready, .rx_data, .rx_sof, .rx_eof,
      .rx_is_ctrl(ctl), .rx_filter_pass(1'b1), .rxb_valid, .rxb_ready, .rxb_data, .rxb_last);
   emc_far_model u_emc_far_model (.ref_clk, .send, .seed, .tx_start, .dma_start, .tx_aborted,
      .dma_done, .rx_valid, .rx_ready, .rx_data, .rx_sof, .rx_eof);
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [2:0] pad_exp(input logic [2:0] c);
      return {c == 3'h5, c == 3'h7 || c == 3'h3, c[0]};
   endfunction
   task automatic report_and_stop();
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [23:0] g, input logic [23:0] e);
      n_tests++;
      if (g !== e)
      begin
         mismatches++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // one access, then a quiet cycle before the next one
   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= w;
      sfr_rd <= !w;
      @(posedge ref_clk);
      sfr_wr <= 1'b0;
      sfr_rd <= 1'b0;
      #1;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk(sfr_rdata, e);
   endtask
   task automatic frame();
      @(posedge ref_clk);
      rnd = xs(rnd);
      seed <= rnd[7:0];
      send <= 1'b1;
      @(posedge ref_clk);
      send <= 1'b0;
      repeat (12) @(posedge ref_clk);
      #1;
   endtask
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         mismatches++;
         report_and_stop();
      end
   end
   initial
   begin
      {sfr_wr, sfr_rd, send, rxb_ready, buf_error, buf_error_tx, ctl} = '0;
      {sfr_addr, sfr_wdata, buf_rd_data, seed} = '0;
      reset = 1'b1;
      rnd = 32'h5afd;
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      chk({tlr, rlr}, 2'b11);
      rdc(`EMC_A_MAIN, 8'h00);
      rdc(`EMC_A_AUX, 8'h80);
      rdc(4'hc, 8'h00);
      acc(1'b1, `EMC_A_AUX, 8'ha0);
      rdc(`EMC_A_STAT, 8'h00);
      chk({tlr, rlr}, 2'b00);
      rdc(`EMC_A_MAC3, 8'h00);
      repeat (12) @(posedge ref_clk);
      rdc(`EMC_A_STAT, 8'h01);
      acc(1'b1, `EMC_A_MAIN, 8'hc8);
      chk({tlr, rlr}, 2'b11);
      rdc(`EMC_A_MAIN, 8'hc0);
      acc(1'b1, `EMC_A_MAIN, 8'h00);
      chk({tlr, rlr}, 2'b00);
      for (int c = 0; c < 8; c++)
      begin
         rnd = xs(rnd);
         v = {c[2:0], rnd[4] | c[0], rnd[3:0]};
         acc(1'b1, `EMC_A_MAC3, v);
         rdc(`EMC_A_MAC3, v);
         chk({pad_vlan_auto, pad_to_64, pad_enable}, pad_exp(c[2:0]));
         chk({tce, hfe, lce, fde}, {v[4], v[2:0]});
         chk(crc_skip_bytes, v[3] ? 3'h4 : 3'h0);
         acc(1'b1, `EMC_A_MAC1, rnd[12:5]);
         rdc(`EMC_A_MAC1, rnd[12:5] & 8'h0f);
         chk({pte, pre}, rnd[8:7]);
      end
      acc(1'b1, `EMC_A_MAIN, 8'h08);
      rdc(`EMC_A_MAIN, 8'h08);
      repeat (12) @(posedge ref_clk);
      rdc(`EMC_A_MAIN, 8'h00);
      rdc(`EMC_A_STAT, 8'h03);
      acc(1'b1, `EMC_A_STAT, 8'h00);
      rdc(`EMC_A_STAT, 8'h01);
      acc(1'b1, `EMC_A_MAIN, 8'h30);
      chk(dma_checksum_select, 1'b1);
      rdc(`EMC_A_MAIN, 8'h30);
      repeat (12) @(posedge ref_clk);
      rdc(`EMC_A_MAIN, 8'h10);
      rnd = xs(rnd);
      buf_rd_data <= rnd[7:0];
      acc(1'b1, `EMC_A_RDL, 8'hff);
      acc(1'b1, `EMC_A_RDH, 8'h01);
      rdc(`EMC_A_DATA, rnd[7:0]);
      chk(rdp, 13'h0200);
      acc(1'b1, `EMC_A_AUX, 8'h20);
      acc(1'b1, `EMC_A_WRL, 8'h40);
      acc(1'b1, `EMC_A_WRH, 8'h00);
      acc(1'b1, `EMC_A_DATA, 8'h5a);
      acc(1'b1, `EMC_A_DATA, 8'ha5);
      chk({bwr, buf_wr_addr, buf_wdata}, {1'b1, 13'h0040, 8'ha5});
      rdc(`EMC_A_DATA, rnd[7:0]);
      chk(rdp, 13'h0200);
      acc(1'b1, `EMC_A_AUX, 8'ha0);
      acc(1'b1, `EMC_A_DATA, 8'h3c);
      chk({bwr, buf_wr_addr, buf_wdata}, {1'b1, 13'h0040, 8'h3c});
      rdc(`EMC_A_WRL, 8'h41);
      acc(1'b1, `EMC_A_MAC1, 8'h01);
      acc(1'b1, `EMC_A_MAIN, 8'h04);
      frame();
      chk({rxb_valid, rxb_data}, {1'b1, seed});
      rdc(`EMC_A_STAT, 8'h01);
      @(posedge ref_clk);
      rxb_ready <= 1'b1;
      n = 0;
      repeat (20)
      begin
         @(negedge ref_clk);
         if (rxb_valid === 1'b1)
         begin
            chk({rxb_last, rxb_data}, {n == 3, seed + n[7:0]});
            n++;
         end
      end
      chk(24'(n), 24'h4);
      rdc(`EMC_A_PKTCNT, 8'h01);
      acc(1'b1, `EMC_A_AUX, 8'he0);
      rdc(`EMC_A_AUX, 8'ha0);
      rdc(`EMC_A_PKTCNT, 8'h00);
      acc(1'b1, `EMC_A_MAIN, 8'h00);
      frame();
      chk(rxb_valid, 1'b0);
      rdc(`EMC_A_PKTCNT, 8'h00);
      acc(1'b1, `EMC_A_MAIN, 8'h04);
      @(posedge ref_clk);
      ctl <= 1'b1;
      frame();
      rdc(`EMC_A_PKTCNT, 8'h00);
      acc(1'b1, `EMC_A_MAC1, 8'h03);
      frame();
      rdc(`EMC_A_PKTCNT, 8'h01);
      @(posedge ref_clk);
      buf_error <= 1'b1;
      buf_error_tx <= 1'b1;
      @(posedge ref_clk);
      buf_error <= 1'b0;
      rdc(`EMC_A_STAT, 8'h41);
      rdc(`EMC_A_ERRF, 8'h02);
      acc(1'b1, `EMC_A_ERRF, 8'h00);
      rdc(`EMC_A_ERRF, 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
